/* hw/sacs_pkg.sv */
package sacs_pkg;

  // ***************************************************************
  // widths and timing
  // ***************************************************************
  localparam int unsigned RESULT_W = 18;
  localparam int unsigned CLK_PERIOD_PS = 10000;
  // re-initialization after a power event, least time
  localparam int unsigned REINIT_TIME_NS = 200000;
  // acquisition of the next sample opens this long after start
  localparam int unsigned ACQ_DELAY_NS = 527;
  // acquisition window at full throughput
  localparam int unsigned ACQ_TIME_PS = 1460000;
  // longest conversion time
  localparam int unsigned CONV_TIME_PS = 1500000;
  // early window in which a second trigger edge is harmless
  localparam int unsigned EARLY_WIN_NS = 40;

  // least times round up, longest round down
  localparam int unsigned REINIT_CYC = (REINIT_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned ACQ_DELAY_CYC = (ACQ_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned ACQ_CYC = (ACQ_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned CONV_CYC = CONV_TIME_PS / CLK_PERIOD_PS;
  localparam int unsigned EARLY_CYC = EARLY_WIN_NS * 1000 / CLK_PERIOD_PS;

  localparam int unsigned CNT_W = 16;
  localparam int unsigned SAR_CNT_W = 5;

  typedef enum logic [1:0] {
    SACS_ST_REINIT,
    SACS_ST_NAP,
    SACS_ST_CONV
  } sacs_state_t;

  // result word handed to the serial side
  typedef struct packed {
    logic valid;
    logic [RESULT_W-1:0] code;
  } sacs_result_t;

  // power status carried together
  typedef struct packed {
    logic core_on;
    logic acquiring;
    logic ready;
  } sacs_power_t;

endpackage

/* hw/sacs_sar_engine.sv */
`timescale 1ns/1ps
`default_nettype none

// ***************************************************************
// successive approximation engine: one bit per step, msb first
// ***************************************************************
module sacs_sar_engine (
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic i_start,
  input wire logic i_step,
  input wire logic i_cmp_high,
  output logic [sacs_pkg::RESULT_W-1:0] o_code,
  output logic o_done
);
  import sacs_pkg::*;

  logic [RESULT_W-1:0] trial_r;
  logic [SAR_CNT_W-1:0] bit_r;
  logic active_r;

  // each step keeps or drops the trial bit, then tries the next lower one
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      trial_r <= '0;
      bit_r <= '0;
      active_r <= 1'b0;
    end else if (i_start) begin
      trial_r <= {1'b1, {(RESULT_W-1){1'b0}}};
      bit_r <= SAR_CNT_W'(RESULT_W - 1);
      active_r <= 1'b1;
    end else if (active_r && i_step) begin
      if (!i_cmp_high) begin
        trial_r[bit_r] <= 1'b0;
      end
      if (bit_r != '0) begin
        trial_r[bit_r - SAR_CNT_W'(1)] <= 1'b1;
        bit_r <= bit_r - SAR_CNT_W'(1);
      end else begin
        active_r <= 1'b0;
      end
    end
  end

  // offset binary from the dac becomes two's complement by flipping the msb
  assign o_code = {~trial_r[RESULT_W-1], trial_r[RESULT_W-2:0]};
  assign o_done = ~active_r;

endmodule

`default_nettype wire

/* hw/sacs_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none

// Function
// - Power-on reset is applied at power-up and whenever supply drops below 2V.
// - When supply returns, the converter is re-initialized before normal work.
// - A conversion started before re-initialization ends gives a result marked invalid.
// - A rising trigger edge starts a conversion and powers the core.
// - Trigger edges during a conversion do not restart it.
// - Busy is high for the whole conversion and drops when it completes.
// - Acquisition of the next input begins 527ns after conversion start.
// - An acquisition period of 1.460us is provided in each cycle at full rate.
// - Each conversion lasts at most 1.5us, timed internally.
// - After a conversion the core naps until the next starting edge.
// - In nap only the core is powered down; the rest stays active.
// - The last result is retained during nap for readout.
// - At the end of conversion the result is an 18-bit output word.
// - The result is in two's complement form.
module sacs_sequencer (
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic i_supply_ok,
  input wire logic i_conversion_trigger,
  input wire logic i_cmp_high,
  output logic o_busy,
  output sacs_pkg::sacs_power_t o_power,
  output logic o_sample_hold,
  output logic o_iface_on,
  output sacs_pkg::sacs_result_t o_result
);
  import sacs_pkg::*;

  // ***************************************************************
  // input synchronisers
  // ***************************************************************
  logic trig_m_r, trig_s_r, trig_d_r;
  logic sup_m_r, sup_s_r;

  // first stage feeds only the second stage
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      trig_m_r <= 1'b0;
      trig_s_r <= 1'b0;
      trig_d_r <= 1'b0;
      sup_m_r <= 1'b0;
      sup_s_r <= 1'b0;
    end else begin
      trig_m_r <= i_conversion_trigger;
      trig_s_r <= trig_m_r;
      trig_d_r <= trig_s_r;
      sup_m_r <= i_supply_ok;
      sup_s_r <= sup_m_r;
    end
  end

  logic trig_rise;
  assign trig_rise = trig_s_r & ~trig_d_r;

  // ***************************************************************
  // state and counters
  // ***************************************************************
  sacs_state_t state_r, state_nxt;
  logic [CNT_W-1:0] reinit_cnt_r;
  logic [CNT_W-1:0] conv_cnt_r;
  logic [CNT_W-1:0] acq_cnt_r;
  logic suspect_r;
  logic conv_end;

  // the sar engine steps evenly so all 18 bits finish inside the time budget
  localparam logic [CNT_W-1:0] STEP_DIV = CNT_W'((CONV_CYC - 2) / RESULT_W);
  localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYC - 1);
  localparam logic [CNT_W-1:0] REINIT_LAST = CNT_W'(REINIT_CYC - 1);
  localparam logic [CNT_W-1:0] ACQ_START = CNT_W'(ACQ_DELAY_CYC);
  localparam logic [CNT_W-1:0] ACQ_LEN = CNT_W'(ACQ_CYC);

  function automatic logic cnt_hit(input logic [CNT_W-1:0] cnt, input logic [CNT_W-1:0] lim);
    cnt_hit = (cnt == lim);
  endfunction

  assign conv_end = (state_r == SACS_ST_CONV) && cnt_hit(conv_cnt_r, CONV_LAST);

  logic reinit_done;
  // the timer keeps running through an early conversion, so later ones stay flagged until it ends
  assign reinit_done = cnt_hit(reinit_cnt_r, REINIT_LAST);

  // next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      SACS_ST_REINIT: begin
        // a trigger wins over the timer end, so an edge on that cycle is not lost
        if (trig_rise) begin
          state_nxt = SACS_ST_CONV;
        end else if (reinit_done) begin
          state_nxt = SACS_ST_NAP;
        end
      end
      SACS_ST_NAP: begin
        if (trig_rise) begin
          state_nxt = SACS_ST_CONV;
        end
      end
      SACS_ST_CONV: begin
        if (conv_end) begin
          // an early conversion hands back to the re-initialization still under way
          state_nxt = reinit_done ? SACS_ST_NAP : SACS_ST_REINIT;
        end
      end
      default: state_nxt = SACS_ST_REINIT;
    endcase
  end

  // a supply dip sends the block back to re-initialization from anywhere
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_r <= SACS_ST_REINIT;
    end else if (!sup_s_r) begin
      state_r <= SACS_ST_REINIT;
    end else begin
      state_r <= state_nxt;
    end
  end

  // re-initialization timer runs only while supply is good
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      reinit_cnt_r <= '0;
    end else if (!sup_s_r) begin
      reinit_cnt_r <= '0;
    end else if (!reinit_done) begin
      reinit_cnt_r <= reinit_cnt_r + CNT_W'(1);
    end
  end

  // a conversion started before the timer expired is flagged
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      suspect_r <= 1'b0;
    end else if (trig_rise && state_r != SACS_ST_CONV) begin
      suspect_r <= !reinit_done || !sup_s_r;
    end
  end

  // conversion timer; edges inside a conversion never reload it
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      conv_cnt_r <= '0;
    end else if (state_r != SACS_ST_CONV) begin
      conv_cnt_r <= '0;
    end else if (!conv_end) begin
      conv_cnt_r <= conv_cnt_r + CNT_W'(1);
    end
  end

  // ***************************************************************
  // sar engine
  // ***************************************************************
  logic sar_start, sar_step, sar_done;
  logic [RESULT_W-1:0] sar_code;
  logic [CNT_W-1:0] step_cnt_r;

  assign sar_start = (state_nxt == SACS_ST_CONV) && (state_r != SACS_ST_CONV) && sup_s_r;
  // the step counter runs 0 to STEP_DIV-1, one bit every STEP_DIV cycles
  assign sar_step = (state_r == SACS_ST_CONV) && cnt_hit(step_cnt_r, STEP_DIV - CNT_W'(1));

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      step_cnt_r <= '0;
    end else if (state_r != SACS_ST_CONV || sar_step) begin
      step_cnt_r <= '0;
    end else begin
      step_cnt_r <= step_cnt_r + CNT_W'(1);
    end
  end

  sacs_sar_engine u_sar (
    .i_clk_sys(i_clk_sys),
    .i_arst_n(i_arst_n),
    .i_start(sar_start),
    .i_step(sar_step),
    .i_cmp_high(i_cmp_high),
    .o_code(sar_code),
    .o_done(sar_done)
  );

  // ***************************************************************
  // acquisition window
  // ***************************************************************
  // the next sample is tracked from a fixed delay after start until the conversion ends, and on through nap
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      acq_cnt_r <= '0;
    end else if (sar_start) begin
      acq_cnt_r <= '0;
    end else if (!cnt_hit(acq_cnt_r, ACQ_START + ACQ_LEN)) begin
      acq_cnt_r <= acq_cnt_r + CNT_W'(1);
    end
  end

  logic acquiring;
  // in nap the sampler keeps tracking until the next start edge
  assign acquiring = (state_r == SACS_ST_NAP) ||
    (state_r == SACS_ST_CONV && acq_cnt_r >= ACQ_START);

  // ***************************************************************
  // result and outputs
  // ***************************************************************
  // result code changes only on the cycle busy falls; a supply dip also clears valid
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_result <= '0;
    end else if (conv_end && sup_s_r) begin
      o_result.code <= sar_code;
      o_result.valid <= ~suspect_r & sar_done;
    end else if (!sup_s_r) begin
      o_result.valid <= 1'b0;
    end
  end

  assign o_busy = (state_r == SACS_ST_CONV);
  assign o_power.core_on = (state_r == SACS_ST_CONV);
  assign o_power.acquiring = acquiring;
  assign o_power.ready = (state_r == SACS_ST_NAP);
  assign o_sample_hold = ~acquiring;
  // interface keeps power in nap so the kept word can still be shifted out
  assign o_iface_on = (state_r != SACS_ST_REINIT) || o_result.valid;

  // ***************************************************************
  // checks
  // ***************************************************************
  sequence s_start;
    trig_rise && state_r == SACS_ST_NAP && sup_s_r;
  endsequence

  chk_start_busy: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    s_start |=> o_busy) else $error("busy did not rise after trigger");
  chk_conv_len: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    s_start |=> (o_busy && sup_s_r)[*1] ##150 (!o_busy || !sup_s_r))
    else $error("conversion length wrong");
  chk_no_restart: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    (o_busy && trig_rise && !conv_end) |=>
    ($stable(u_sar.bit_r) || $past(sar_step)) && conv_cnt_r != '0)
    else $error("conversion restarted");
  chk_busy_hold: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    $fell(o_busy) && sup_s_r |-> $past(conv_end)) else $error("busy fell early");
  chk_nap_hold: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    (state_r == SACS_ST_NAP && !trig_rise && sup_s_r) |=> !o_busy)
    else $error("left nap without edge");
  chk_result_keep: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    (o_busy && !conv_end) |=> $stable(o_result.code)) else $error("result changed early");
  chk_acq_delay: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    sar_start |=> !acquiring [*8]) else $error("acquisition began too early");
  chk_por_reinit: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    !sup_s_r |=> state_r == SACS_ST_REINIT && reinit_cnt_r == '0)
    else $error("supply dip did not reset");
  chk_early_invalid: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    (conv_end && suspect_r) |=> !o_result.valid) else $error("early result marked valid");

endmodule

`default_nettype wire

/* sim/sacs_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ***************************************************************
// host model: trigger pin and comparator answer
// ***************************************************************
module sacs_host_model (
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic i_busy,
  input wire logic i_start,
  input wire logic i_early_ok,
  input wire logic i_glitch,
  input wire logic i_cmp,
  output logic o_conversion_trigger,
  output logic o_cmp_high
);
  import sacs_pkg::*;
  int unsigned up_cnt;

  // host's own count of the re-initialization time since reset
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      up_cnt <= 0;
    end else if (up_cnt < REINIT_CYC + 3) begin
      up_cnt <= up_cnt + 1;
    end
  end

  // comparator level is held for the whole conversion
  assign o_cmp_high = i_cmp;

  // one trigger per request; the pin falls inside the early window
  initial begin
    o_conversion_trigger = 1'b0;
    forever begin
      @(posedge i_clk_sys);
      if (i_start && (up_cnt >= REINIT_CYC + 3 || i_early_ok)) begin
        #1 o_conversion_trigger = 1'b1;
        // fall one cycle short of the early window so the edge stays harmless
        repeat (EARLY_CYC - 1) @(posedge i_clk_sys);
        #1 o_conversion_trigger = 1'b0;
        // a stray pulse mid conversion, only when a test asks for it
        if (i_glitch) begin
          repeat (20) @(posedge i_clk_sys);
          #1 o_conversion_trigger = 1'b1;
          repeat (5) @(posedge i_clk_sys);
          #1 o_conversion_trigger = 1'b0;
        end
        @(posedge i_clk_sys);
        while (i_busy) @(posedge i_clk_sys);
      end
    end
  end
endmodule

`default_nettype wire

/* sim/tb.sv */
`timescale 1ns/1ps
`default_nettype none

module tb;
  import sacs_pkg::*;
  typedef struct {logic cmp; logic [RESULT_W-1:0] code;} sacs_row_t;
  logic i_clk_sys, i_arst_n, i_supply_ok, trig, cmp_high, o_busy, o_sample_hold, o_iface_on;
  logic start_m, early_m, glitch_m, cmp_m;
  sacs_power_t o_power;
  sacs_result_t o_result;
  int n_fail = 0;
  int n_tests = 0;
  sacs_row_t rows [3] = '{'{1'b1, 18'h1ffff}, '{1'b0, 18'h20000}, '{1'b1, 18'h1ffff}};

  sacs_sequencer DUT (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_supply_ok(i_supply_ok),
    .i_conversion_trigger(trig), .i_cmp_high(cmp_high), .o_busy(o_busy), .o_power(o_power),
    .o_sample_hold(o_sample_hold), .o_iface_on(o_iface_on), .o_result(o_result));
  sacs_host_model host (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_busy(o_busy),
    .i_start(start_m), .i_early_ok(early_m), .i_glitch(glitch_m), .i_cmp(cmp_m),
    .o_conversion_trigger(trig), .o_cmp_high(cmp_high));

  // ***************************************************************
  // clock, compare and verdict
  // ***************************************************************
  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // one conversion; per-cycle faults are gathered into flags
  task automatic convert(input logic cmp, glitch, early, exp_valid,
                         input logic [RESULT_W-1:0] exp_code, input logic chk_code);
    sacs_result_t held;
    int k;
    int acq_at;
    logic bad_hold, core_off, acq_drop, rebusy;
    logic [RESULT_W-1:0] done_code;
    cmp_m = cmp;
    glitch_m = glitch;
    early_m = early;
    bad_hold = 0;
    core_off = 0;
    acq_drop = 0;
    rebusy = 0;
    @(posedge i_clk_sys); #1 start_m = 1'b1;
    @(posedge i_clk_sys); #1 start_m = 1'b0;
    k = 0;
    while (o_busy !== 1'b1 && k < 20) begin
      @(posedge i_clk_sys); #1 k++;
    end
    held = o_result;
    k = 0;
    acq_at = -1;
    while (o_busy === 1'b1 && k < 400) begin
      if (o_result !== held) bad_hold = 1;
      if (o_power.core_on !== 1'b1) core_off = 1;
      if (acq_at >= 0 && o_power.acquiring !== 1'b1) acq_drop = 1;
      if (acq_at < 0 && o_power.acquiring === 1'b1) acq_at = k;
      @(posedge i_clk_sys); #1 k++;
    end
    check("busy_cycles", k, CONV_CYC);
    check("acq_start", acq_at, ACQ_DELAY_CYC);
    check("acq_held", acq_drop, 0);
    check("result_held", bad_hold, 0);
    check("core_on_conv", core_off, 0);
    check("valid", o_result.valid, exp_valid);
    if (chk_code) check("code", o_result.code, exp_code);
    done_code = chk_code ? exp_code : o_result.code;
    repeat (10) begin
      if (o_busy !== 1'b0 || o_power.core_on !== 1'b0) rebusy = 1;
      @(posedge i_clk_sys); #1;
    end
    check("nap_no_restart", rebusy, 0);
    // an early conversion falls back to re-initialization, not to nap
    check("iface_nap", o_iface_on, !early);
    check("ready_nap", o_power.ready, !early);
    check("sample_hold", o_sample_hold, early);
    check("kept_code", o_result.code, done_code);
    check("retained", o_result.valid, exp_valid);
    $display("test conversion cmp=%0b glitch=%0b early=%0b done", cmp, glitch, early);
  endtask

  // ***************************************************************
  // scenarios
  // ***************************************************************
  initial begin
    i_arst_n = 1'b0;
    i_supply_ok = 1'b1;
    start_m = 1'b0;
    early_m = 1'b0;
    glitch_m = 1'b0;
    cmp_m = 1'b0;
    repeat (4) @(posedge i_clk_sys);
    #1 check("busy_rst", o_busy, 0);
    check("iface_rst", o_iface_on, 0);
    check("result_rst", o_result, 0);
    i_arst_n = 1'b1;
    $display("test reset done");
    convert(1'b1, 1'b0, 1'b1, 1'b0, '0, 1'b0);
    repeat (REINIT_CYC) @(posedge i_clk_sys);
    foreach (rows[i]) convert(rows[i].cmp, 1'b0, 1'b0, 1'b1, rows[i].code, 1'b1);
    convert(1'b0, 1'b1, 1'b0, 1'b1, 18'h20000, 1'b1);
    // brown-out: the result is no longer trusted
    #1 i_supply_ok = 1'b0;
    repeat (10) @(posedge i_clk_sys);
    #1 check("valid_dip", o_result.valid, 0);
    i_supply_ok = 1'b1;
    $display("test supply dip done");
    convert(1'b1, 1'b0, 1'b1, 1'b0, '0, 1'b0);
    // second reset in mid run
    @(posedge i_clk_sys); #1 i_arst_n = 1'b0;
    #1 check("busy_rst2", o_busy, 0);
    check("result_rst2", o_result, 0);
    @(posedge i_clk_sys); #1 i_arst_n = 1'b1;
    repeat (2) @(posedge i_clk_sys);
    #1 check("busy_rel2", o_busy, 0);
    check("ready_rel2", o_power.ready, 0);
    check("iface_rel2", o_iface_on, 0);
    $display("test second reset done");
    report_and_stop();
  end

  // about 21000 cycles expected; cut a hang at 60000
  initial begin
    #600000;
    n_fail++;
    report_and_stop();
  end
endmodule

`default_nettype wire
